// ### hw/wake_pkg.sv
// constants for the wake event, status and ready block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
package wake_pkg;
	localparam logic [7:0] power_mgmt_control_offset = 8'h84;
	localparam int ready_bit = 0;
	localparam int out_enable_bit = 1;
	localparam int polarity_bit = 2;
	localparam int pulse_select_bit = 3;
	localparam int cause_lsb = 4;
	localparam int buffer_type_bit = 6;
	localparam int energy_enable_bit = 8;
	localparam int frame_enable_bit = 9;
	localparam int state_lsb = 12;
	localparam logic [1:0] cause_none = 2'h0;
	localparam logic [1:0] cause_energy = 2'h1;
	localparam logic [1:0] cause_frame = 2'h2;
	localparam logic [1:0] cause_multiple = 2'h3;
	localparam logic [1:0] state_normal = 2'h0;
	localparam logic [1:0] state_wake_detect = 2'h1;
	localparam logic [1:0] state_energy_detect = 2'h2;
	localparam logic [1:0] state_reserved = 2'h3;
	localparam longint clock_hz = 200000000;
	localparam longint pulse_ms = 50;
	localparam longint pulse_cycles = (pulse_ms * clock_hz) / 1000;
	localparam longint settle_cycles = 16;
endpackage
`default_nettype wire

// ### hw/wake_pulse_timer.sv
// down-counter that times the wake event output pulse
`default_nettype none
module wake_pulse_timer #(
	parameter int count_width = 24,
	parameter logic [23:0] pulse_len = 24'(wake_pkg::pulse_cycles)
) (
	input wire logic clock,
	input wire logic soft_reset_cmd,
	input wire logic start,
	input wire logic abort,
	output logic busy
);
	logic [count_width-1:0] remain;

	// a new start during a pulse restarts the full length
	always_ff @(posedge clock) begin
		if (soft_reset_cmd || abort) begin
			remain <= '0;
		end else if (start) begin
			remain <= count_width'(pulse_len);
		end else if (remain != '0) begin
			remain <= remain - count_width'(1);
		end
	end

	assign busy = (remain != '0);

	pulse_len_a: assert property (@(posedge clock) disable iff (soft_reset_cmd || abort)
		start |=> busy [*8])
		else $error("pulse ended too early");
endmodule // wake_pulse_timer
`default_nettype wire

// ### hw/wake_event_status_and_ready.sv
// wake cause status, wake event output shaping and device ready flag
//
// The strobed register port and the address map were left to the implementer.
`default_nettype none
module wake_event_status_and_ready #(
	parameter logic [23:0] pulse_len = 24'(wake_pkg::pulse_cycles),
	parameter logic [7:0] settle_len = 8'(wake_pkg::settle_cycles)
) (
	input wire logic clock,
	input wire logic soft_reset_cmd,
	input wire logic [7:0] address,
	input wire logic [31:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [31:0] read_data,
	input wire logic energy_event,
	input wire logic frame_event,
	input wire logic energy_source_active,
	input wire logic frame_source_active,
	input wire logic power_wakeup,
	output logic [1:0] power_state_select,
	output logic wake_event_interrupt,
	output logic wake_event_output_o,
	output logic wake_event_output_oe
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [1:0] wake_cause_status;
	logic wake_out_pulse_select;
	logic wake_out_polarity;
	logic wake_out_enable;
	logic wake_out_buffer_type;
	logic energy_detect_enable;
	logic wake_frame_enable;
	logic ready;
	logic [7:0] settle_count;
	logic hit;
	logic wr;
	logic [1:0] clear_req;
	logic [1:0] new_cause;
	logic [1:0] next_cause;
	logic event_fire;
	logic pulse_busy;
	logic enables_dropped;
	logic wake_active;
	logic level_active;

	assign hit = (address == wake_pkg::power_mgmt_control_offset);
	assign wr = write_strobe && hit;

	// ----------------------------------------------------------------
	// configuration bits
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_reset_cmd) begin
			wake_out_pulse_select <= 1'b0;
			wake_out_polarity <= 1'b0;
			wake_out_enable <= 1'b0;
			wake_out_buffer_type <= 1'b0;
			energy_detect_enable <= 1'b0;
			wake_frame_enable <= 1'b0;
		end else if (wr) begin
			wake_out_pulse_select <= write_data[wake_pkg::pulse_select_bit];
			wake_out_polarity <= write_data[wake_pkg::polarity_bit];
			wake_out_enable <= write_data[wake_pkg::out_enable_bit];
			wake_out_buffer_type <= write_data[wake_pkg::buffer_type_bit];
			energy_detect_enable <= write_data[wake_pkg::energy_enable_bit];
			wake_frame_enable <= write_data[wake_pkg::frame_enable_bit];
		end
	end

	// reserved code 11b is refused so the block never enters it
	always_ff @(posedge clock) begin
		if (soft_reset_cmd || power_wakeup) begin
			power_state_select <= wake_pkg::state_normal;
		end else if (wr && write_data[wake_pkg::state_lsb +: 2] != wake_pkg::state_reserved) begin
			power_state_select <= write_data[wake_pkg::state_lsb +: 2];
		end
	end

	// ----------------------------------------------------------------
	// ready flag: drops on power-state change, rises after settling
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_reset_cmd || (wr && write_data[wake_pkg::state_lsb +: 2] != wake_pkg::state_normal
				&& write_data[wake_pkg::state_lsb +: 2] != wake_pkg::state_reserved)) begin
			ready <= 1'b0;
			settle_count <= settle_len;
		end else if (power_wakeup) begin
			ready <= 1'b0;
			settle_count <= settle_len;
		end else if (power_state_select == wake_pkg::state_normal) begin
			if (settle_count != 8'h00) begin
				settle_count <= settle_count - 8'h01;
			end else begin
				ready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// wake cause status
	// ----------------------------------------------------------------
	assign new_cause = {frame_event && wake_frame_enable, energy_event && energy_detect_enable};
	assign event_fire = |new_cause;

	// a clear only takes while ready and the matching source is quiet
	always_comb begin
		clear_req = 2'h0;
		if (wr && ready) begin
			clear_req = write_data[wake_pkg::cause_lsb +: 2];
		end
		clear_req = clear_req & ~{frame_source_active, energy_source_active};
		next_cause = (wake_cause_status & ~clear_req) | new_cause;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (soft_reset_cmd) begin
			wake_cause_status <= wake_pkg::cause_none;
		end else begin
			wake_cause_status <= next_cause;
		end
	end

	// ----------------------------------------------------------------
	// wake event output shaping
	// ----------------------------------------------------------------
	assign enables_dropped = wr && !write_data[wake_pkg::energy_enable_bit]
		&& !write_data[wake_pkg::frame_enable_bit];

	wake_pulse_timer #(
		.count_width(24),
		.pulse_len(pulse_len)
	) pulse_timer (
		.clock(clock),
		.soft_reset_cmd(soft_reset_cmd),
		.start(event_fire && wake_out_pulse_select),
		.abort(next_cause == wake_pkg::cause_none || enables_dropped),
		.busy(pulse_busy)
	);

	// level mode follows the sticky cause while its enable stays on
	assign level_active = |(wake_cause_status & {wake_frame_enable, energy_detect_enable});
	assign wake_active = wake_out_pulse_select ? pulse_busy : level_active;

	// interrupt ignores the output enable
	always_ff @(posedge clock) begin
		if (soft_reset_cmd) begin
			wake_event_interrupt <= 1'b0;
		end else begin
			wake_event_interrupt <= |next_cause;
		end
	end

	// open-drain pulls low when active and floats otherwise
	always_ff @(posedge clock) begin
		if (soft_reset_cmd) begin
			wake_event_output_o <= 1'b0;
			wake_event_output_oe <= 1'b0;
		end else if (!wake_out_enable) begin
			wake_event_output_o <= 1'b0;
			wake_event_output_oe <= 1'b0;
		end else if (!wake_out_buffer_type) begin
			wake_event_output_o <= 1'b0;
			wake_event_output_oe <= wake_active;
		end else begin
			wake_event_output_o <= wake_active ~^ wake_out_polarity;
			wake_event_output_oe <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// read port: answers whatever the ready state
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_reset_cmd) begin
			read_data <= 32'h00000000;
		end else if (read_strobe && hit) begin
			read_data <= 32'h00000000;
			read_data[wake_pkg::state_lsb +: 2] <= power_state_select;
			read_data[wake_pkg::frame_enable_bit] <= wake_frame_enable;
			read_data[wake_pkg::energy_enable_bit] <= energy_detect_enable;
			read_data[wake_pkg::buffer_type_bit] <= wake_out_buffer_type;
			read_data[wake_pkg::cause_lsb +: 2] <= wake_cause_status;
			read_data[wake_pkg::pulse_select_bit] <= wake_out_pulse_select;
			read_data[wake_pkg::polarity_bit] <= wake_out_polarity;
			read_data[wake_pkg::out_enable_bit] <= wake_out_enable;
			read_data[wake_pkg::ready_bit] <= ready;
		end else begin
			read_data <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence frame_seen;
		frame_event && wake_frame_enable;
	endsequence

	sequence clear_written;
		wr && ready && write_data[wake_pkg::cause_lsb +: 2] == 2'h3 && !energy_event
			&& !frame_event && !energy_source_active && !frame_source_active;
	endsequence

	cause_set_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		frame_seen |=> wake_cause_status[1])
		else $error("frame cause not latched");

	cause_clear_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		clear_written |=> wake_cause_status == 2'h0)
		else $error("cause not cleared");

	clear_unready_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		(!ready && !wr) ##0 (wake_cause_status != 2'h0) |=> wake_cause_status != 2'h0)
		else $error("cause lost while unready");

	source_hold_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wake_cause_status[0] && energy_source_active |=> wake_cause_status[0])
		else $error("cause cleared with active source");

	level_drive_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wake_out_enable && wake_out_buffer_type && !wake_out_pulse_select && level_active
		&& $stable(wake_out_polarity) |=> wake_event_output_o == $past(wake_out_polarity))
		else $error("level output not active");

	open_drain_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wake_event_output_oe && !$past(wake_out_buffer_type) |-> !wake_event_output_o)
		else $error("open drain driven high");

	enable_gate_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		!wake_out_enable |=> !wake_event_output_oe)
		else $error("output driven while disabled");

	irq_always_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		frame_seen |=> wake_event_interrupt)
		else $error("interrupt missing");

	reserved_mode_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		1'b1 |-> power_state_select != wake_pkg::state_reserved)
		else $error("reserved power state entered");

	sequence pulse_launch;
		event_fire && wake_out_pulse_select && !wr;
	endsequence

	sequence level_idle;
		wake_out_enable && wake_out_buffer_type && !wake_out_pulse_select && !wr
			&& !level_active;
	endsequence

	mode_write_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wr && !power_wakeup && write_data[wake_pkg::state_lsb +: 2] != wake_pkg::state_reserved
		|=> power_state_select == $past(write_data[wake_pkg::state_lsb +: 2]))
		else $error("power state not taken");

	wake_return_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		power_wakeup |=> !ready && power_state_select == wake_pkg::state_normal)
		else $error("wakeup did not restart settling");

	ready_wait_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		!ready && settle_count != 8'h00 |=> !ready)
		else $error("ready before settling");

	cause_both_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wake_cause_status[1] && energy_event && energy_detect_enable && !wr
		|=> wake_cause_status == wake_pkg::cause_multiple)
		else $error("multiple causes not reported");

	frame_hold_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wake_cause_status[1] && frame_source_active |=> wake_cause_status[1])
		else $error("frame cause cleared with active source");

	energy_irq_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		energy_event && energy_detect_enable |=> wake_event_interrupt && wake_cause_status[0])
		else $error("energy event not raised");

	frame_out_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		frame_seen ##0 (wake_out_enable && !wr) |=> ##1 wake_event_output_oe)
		else $error("frame event not on pin");

	pulse_start_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		pulse_launch |=> pulse_busy && wake_active)
		else $error("pulse not started");

	pulse_stop_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		enables_dropped || next_cause == wake_pkg::cause_none |=> !pulse_busy)
		else $error("pulse outlived its cause");

	level_idle_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		level_idle |=> wake_event_output_oe && wake_event_output_o == !wake_out_polarity)
		else $error("level output not released");

	push_pull_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		wake_out_enable && wake_out_buffer_type && !wr |=> wake_event_output_oe
		&& wake_event_output_o == ($past(wake_active) ? wake_out_polarity : !wake_out_polarity))
		else $error("push-pull level wrong");

	read_zero_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		!(read_strobe && hit) |=> read_data == 32'h00000000)
		else $error("read data outside its cycle");

	read_ready_a: assert property (@(posedge clock) disable iff (soft_reset_cmd)
		read_strobe && hit |=> read_data[wake_pkg::ready_bit] == $past(ready)
		&& read_data[wake_pkg::cause_lsb +: 2] == $past(wake_cause_status))
		else $error("read data stale");
endmodule // wake_event_status_and_ready
`default_nettype wire

// ### tb/wake_watcher.sv
// model of the system power controller watching the wake event pin
`default_nettype none
module wake_watcher (
	input wire logic clock,
	input wire logic soft_reset_cmd,
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic active_high,
	output logic level,
	output logic active,
	output logic [31:0] width
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] run;
	// board pull-up holds the wired-or line high when nobody drives it
	assign level = pin_oe ? pin_o : 1'b1;
	assign active = active_high ? level : ~level;
	always @(posedge clock) begin
		if (soft_reset_cmd) begin
			run <= 32'h0;
			width <= 32'h0;
		end else if (active) begin
			run <= run + 32'h1;
		end else begin
			if (run != 32'h0) width <= run;
			run <= 32'h0;
		end
	end
endmodule // wake_watcher
`default_nettype wire

// ### tb/test_wake_event_status_and_ready.sv
// bench for the wake event, status and ready block
`default_nettype none
module test_wake_event_status_and_ready;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] plen = 24'h14;
	localparam logic [31:0] cfg = 32'h346;
	localparam logic [31:0] cfg2 = 32'h30E;
	localparam logic [31:0] cfg3 = 32'h340;
	logic clock = 1'b0;
	logic soft_reset_cmd = 1'b1;
	logic [7:0] address = 8'h0;
	logic [31:0] write_data = 32'h0;
	logic write_strobe = 1'b0, read_strobe = 1'b0;
	logic [31:0] read_data, width, v;
	logic energy_event = 1'b0, frame_event = 1'b0, power_wakeup = 1'b0;
	logic energy_source_active = 1'b0, frame_source_active = 1'b0;
	logic [1:0] power_state_select;
	logic wake_event_interrupt, pin_o, pin_oe, level, active;
	logic active_high = 1'b1;
	logic [31:0] seed = 32'h49A0F31E;
	logic [63:0] exp_q[$];
	logic rd_pend = 1'b0;
	int mismatches = 0;
	int n_checks = 0;
	always #2.5 clock = ~clock;
	wake_event_status_and_ready #(.pulse_len(plen), .settle_len(8'h10))
		i_wake_event_status_and_ready (.clock(clock), .soft_reset_cmd(soft_reset_cmd), .address(address),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .energy_event(energy_event), .frame_event(frame_event),
		.energy_source_active(energy_source_active), .frame_source_active(frame_source_active),
		.power_wakeup(power_wakeup), .power_state_select(power_state_select),
		.wake_event_interrupt(wake_event_interrupt), .wake_event_output_o(pin_o),
		.wake_event_output_oe(pin_oe));
	wake_watcher i_wake_watcher (.clock(clock), .soft_reset_cmd(soft_reset_cmd), .pin_o(pin_o), .pin_oe(pin_oe),
		.active_high(active_high), .level(level), .active(active), .width(width));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	// a zero mask marks a poll whose value is judged by the caller
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		exp_q.push_back({e, m});
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 v = read_data;
	endtask
	task automatic pulse_ev(input logic fr);
		@(posedge clock);
		if (fr) frame_event <= 1'b1;
		else energy_event <= 1'b1;
		@(posedge clock);
		frame_event <= 1'b0;
		energy_event <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic wait_ready;
		for (int i = 0; i < 64; i++) begin
			rd(8'h84, 32'h0, 32'h0);
			if (v[0] === 1'b1) break;
		end
		check("ready", {31'h0, v[0]}, 32'h1);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clock) begin
		logic [63:0] n;
		if (rd_pend) begin
			n = exp_q.pop_front();
			if (n[31:0] !== 32'h0) check("read_data", read_data & n[31:0], n[63:32]);
		end
		rd_pend <= read_strobe;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clock);
		soft_reset_cmd <= 1'b0;
		rd(8'h84, 32'h0, 32'hFFFFFFFF);
		wait_ready();
		seed = lfsr(seed);
		wr(8'h80, seed);
		rd(8'h80, 32'h0, 32'hFFFFFFFF);
		seed = lfsr(seed);
		wr(8'h84, cfg | (seed & 32'hFFFFCC80));
		rd(8'h84, cfg | 32'h1, 32'hFFFFFFFF);
		$display("test registers done");
		pulse_ev(1'b1);
		rd(8'h84, 32'h21, 32'h31);
		check("pin", {30'h0, pin_oe, pin_o}, 32'h3);
		pulse_ev(1'b0);
		rd(8'h84, 32'h31, 32'h31);
		@(posedge clock);
		frame_source_active <= 1'b1;
		wr(8'h84, cfg | 32'h30);
		rd(8'h84, 32'h21, 32'h31);
		@(posedge clock);
		frame_source_active <= 1'b0;
		wr(8'h84, cfg | 32'h20);
		rd(8'h84, 32'h1, 32'h31);
		check("pin", {30'h0, pin_oe, pin_o}, 32'h2);
		check("irq", 32'(wake_event_interrupt), 32'h0);
		pulse_ev(1'b1);
		wr(8'h84, cfg & ~32'h300);
		repeat (2) @(posedge clock);
		check("pin", {30'h0, pin_oe, pin_o}, 32'h2);
		wr(8'h84, (cfg & ~32'h300) | 32'h30);
		$display("test level mode done");
		@(posedge clock);
		active_high <= 1'b0;
		wr(8'h84, cfg2);
		pulse_ev(1'b1);
		check("pin", {30'h0, pin_oe, pin_o}, 32'h2);
		repeat (30) @(posedge clock);
		check("width", width, 32'(plen));
		wr(8'h84, cfg2 | 32'h20);
		pulse_ev(1'b1);
		pulse_ev(1'b1);
		repeat (40) @(posedge clock);
		check("width", width, 32'(plen) + 32'h5);
		wr(8'h84, cfg2 | 32'h20);
		$display("test pulse mode done");
		wr(8'h84, cfg3);
		pulse_ev(1'b0);
		check("irq", 32'(wake_event_interrupt), 32'h1);
		check("oe", 32'(pin_oe), 32'h0);
		wr(8'h84, cfg3 | 32'h2);
		repeat (2) @(posedge clock);
		#1;
		check("pin", {30'h0, pin_oe, pin_o}, 32'h2);
		$display("test output enable done");
		for (int s = 1; s < 4; s++) begin
			wr(8'h84, cfg3 | (32'(s) << 12));
			rd(8'h84, (s == 3) ? 32'h1 : (32'(s) << 12), 32'h3001);
			check("state", 32'(power_state_select), (s == 3) ? 32'h0 : 32'(s));
			@(posedge clock);
			power_wakeup <= 1'b1;
			@(posedge clock);
			power_wakeup <= 1'b0;
			wait_ready();
		end
		$display("test power states done");
		finish_test();
	end
endmodule // test_wake_event_status_and_ready
`default_nettype wire
